// File: csb_branch_core.sv
`timescale 1ns/1ns
module csb_branch_core #(
    parameter int ADDR_W = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // run control and state loading while idle
    input wire logic run,
    input wire logic loadEn,
    input wire logic [3:0] loadSel,
    input wire logic [15:0] loadData,
    input wire logic [3:0] viewSel,
    // memory bus
    input wire logic [7:0] memRdData,
    output logic [15:0] memAddr,
    output logic memRdEn,
    output logic memWrEn,
    output logic [7:0] memWrData,
    output logic opFetch,
    // status
    output logic busy,
    output logic instrDone,
    output logic [15:0] regView
);
    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (ADDR_W != 16) begin : gAddrCheck
        $error("address width must be 16");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        csb_pkg::csb_state_e st;
        logic [2:0] tCnt;
        logic [15:0] pc;
        logic [15:0] idx1;
        logic [15:0] idx2;
        logic [7:0][7:0] regs;
        logic [7:0] flags;
        logic [1:0] idxSel;
        logic [7:0] opc;
        logic [7:0] disp;
        logic [7:0] tmpLo;
        logic [15:0] ea;
        logic [15:0] memAddr;
        logic memRdEn;
        logic memWrEn;
        logic [7:0] memWrData;
        logic opFetch;
        logic busy;
        logic instrDone;
        logic [15:0] regView;
    } csb_core_s;

    csb_core_s state_reg;
    csb_core_s state_next;
    csb_exec_if ex ();

    csb_cond_eval uCond (
        .ex(ex.condSide)
    );
    csb_bit_clear uClear (
        .ex(ex.clrSide)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] sext16(logic [7:0] d);
        return {{8{d[7]}}, d};
    endfunction

    function automatic logic [2:0] cycleLen(csb_pkg::csb_state_e st);
        case (st)
            csb_pkg::ST_FETCH: return csb_pkg::T_OPFETCH;
            csb_pkg::ST_BITOP: return csb_pkg::T_OPFETCH;
            csb_pkg::ST_IDXOP: return csb_pkg::T_IDXCALC;
            csb_pkg::ST_MEMRD: return csb_pkg::T_MEMRD4;
            csb_pkg::ST_MEMWR: return csb_pkg::T_MEMWR;
            csb_pkg::ST_RELADD: return csb_pkg::T_RELADD;
            default: return csb_pkg::T_MEMRD3;
        endcase
    endfunction

    // opens a machine cycle; its length fixes every instruction's state count
    function automatic csb_core_s enterCycle(csb_core_s s, csb_pkg::csb_state_e st,
            logic [15:0] a);
        csb_core_s r;
        r = s;
        r.st = st;
        r.tCnt = cycleLen(st);
        r.memAddr = a;
        r.memWrEn = (st == csb_pkg::ST_MEMWR);
        r.memRdEn = (st != csb_pkg::ST_MEMWR) && (st != csb_pkg::ST_RELADD)
            && (st != csb_pkg::ST_IDLE);
        r.opFetch = (st == csb_pkg::ST_FETCH) || (st == csb_pkg::ST_BITOP);
        r.busy = (st != csb_pkg::ST_IDLE);
        return r;
    endfunction

    function automatic csb_core_s finishInstr(csb_core_s s, logic go);
        csb_core_s r;
        r = s;
        r.instrDone = 1'b1;
        r.idxSel = 2'h0;
        if (go) begin
            r = enterCycle(r, csb_pkg::ST_FETCH, r.pc);
        end else begin
            r = enterCycle(r, csb_pkg::ST_IDLE, r.pc);
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // datapath feeds for the condition and clear units
    // ------------------------------------------------------------
    always_comb begin
        ex.flags = state_reg.flags;
        if (state_reg.st == csb_pkg::ST_RELDISP) begin
            ex.condCode = {1'b0, state_reg.opc[4:3]};
        end else begin
            ex.condCode = state_reg.opc[5:3];
        end
        if (state_reg.st == csb_pkg::ST_BITOP) begin
            ex.operand = state_reg.regs[memRdData[2:0]];
            ex.bitSel = memRdData[5:3];
        end else begin
            ex.operand = memRdData;
            ex.bitSel = state_reg.opc[5:3];
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        logic endCyc;
        logic [15:0] pcInc;
        logic [15:0] base;
        endCyc = (state_reg.tCnt == 3'h0);
        pcInc = state_reg.pc + 16'h0001;
        base = (state_reg.idxSel == 2'h2) ? state_reg.idx2 : state_reg.idx1;
        state_next = state_reg;
        state_next.instrDone = 1'b0;
        case (viewSel)
            csb_pkg::SEL_IDX1: state_next.regView = state_reg.idx1;
            csb_pkg::SEL_IDX2: state_next.regView = state_reg.idx2;
            csb_pkg::SEL_PC: state_next.regView = state_reg.pc;
            csb_pkg::SEL_FLAGS: state_next.regView = {8'h00, state_reg.flags};
            default: state_next.regView = {8'h00, state_reg.regs[viewSel[2:0]]};
        endcase
        if (state_reg.st != csb_pkg::ST_IDLE && !endCyc) begin
            state_next.tCnt = state_reg.tCnt - 3'h1;
        end else begin
            case (state_reg.st)
                csb_pkg::ST_IDLE: begin
                    // flags change only here; no instruction writes them
                    if (loadEn) begin
                        case (loadSel)
                            csb_pkg::SEL_IDX1: state_next.idx1 = loadData;
                            csb_pkg::SEL_IDX2: state_next.idx2 = loadData;
                            csb_pkg::SEL_PC: state_next.pc = loadData;
                            csb_pkg::SEL_FLAGS: state_next.flags = loadData[7:0];
                            default: state_next.regs[loadSel[2:0]] = loadData[7:0];
                        endcase
                    end else if (run) begin
                        state_next = enterCycle(state_next, csb_pkg::ST_FETCH, state_reg.pc);
                    end
                end
                csb_pkg::ST_FETCH: begin
                    state_next.opc = memRdData;
                    state_next.pc = pcInc;
                    if (memRdData == csb_pkg::PFX_IDX1 || memRdData == csb_pkg::PFX_IDX2) begin
                        state_next.idxSel = (memRdData == csb_pkg::PFX_IDX2) ? 2'h2 : 2'h1;
                        state_next = enterCycle(state_next, csb_pkg::ST_FETCH, pcInc);
                    end else if (memRdData == csb_pkg::PFX_BIT) begin
                        if (state_reg.idxSel != 2'h0) begin
                            state_next = enterCycle(state_next, csb_pkg::ST_DISP, pcInc);
                        end else begin
                            state_next = enterCycle(state_next, csb_pkg::ST_BITOP, pcInc);
                        end
                    end else if (memRdData == csb_pkg::OP_ABS_JUMP
                            || (memRdData[7:6] == csb_pkg::GRP_ABS_COND
                            && memRdData[2:0] == csb_pkg::LOW_ABS_COND)) begin
                        state_next = enterCycle(state_next, csb_pkg::ST_IMMLO, pcInc);
                    end else if (memRdData == csb_pkg::OP_REL_JUMP
                            || memRdData == csb_pkg::OP_REL_CARRY
                            || memRdData == csb_pkg::OP_REL_NOCARRY) begin
                        state_next = enterCycle(state_next, csb_pkg::ST_RELDISP, pcInc);
                    end else begin
                        // opcodes served elsewhere pass as a four-state no-op
                        state_next = finishInstr(state_next, run);
                    end
                end
                csb_pkg::ST_BITOP: begin
                    state_next.opc = memRdData;
                    state_next.pc = pcInc;
                    if (memRdData[7:6] != csb_pkg::GRP_CLEAR) begin
                        state_next = finishInstr(state_next, run);
                    end else if (memRdData[2:0] == csb_pkg::FIELD_MEM) begin
                        state_next.ea = {state_reg.regs[4], state_reg.regs[5]};
                        state_next = enterCycle(state_next, csb_pkg::ST_MEMRD, state_next.ea);
                    end else begin
                        state_next.regs[memRdData[2:0]] = ex.cleared;
                        state_next = finishInstr(state_next, run);
                    end
                end
                csb_pkg::ST_DISP: begin
                    state_next.disp = memRdData;
                    state_next.pc = pcInc;
                    state_next = enterCycle(state_next, csb_pkg::ST_IDXOP, pcInc);
                end
                csb_pkg::ST_IDXOP: begin
                    state_next.opc = memRdData;
                    state_next.pc = pcInc;
                    state_next.ea = base + sext16(state_reg.disp);
                    if (memRdData[7:6] == csb_pkg::GRP_CLEAR) begin
                        state_next = enterCycle(state_next, csb_pkg::ST_MEMRD, state_next.ea);
                    end else begin
                        state_next = finishInstr(state_next, run);
                    end
                end
                csb_pkg::ST_MEMRD: begin
                    state_next.memWrData = ex.cleared;
                    state_next = enterCycle(state_next, csb_pkg::ST_MEMWR, state_reg.ea);
                end
                csb_pkg::ST_MEMWR: begin
                    state_next = finishInstr(state_next, run);
                end
                csb_pkg::ST_IMMLO: begin
                    state_next.tmpLo = memRdData;
                    state_next.pc = pcInc;
                    state_next = enterCycle(state_next, csb_pkg::ST_IMMHI, pcInc);
                end
                csb_pkg::ST_IMMHI: begin
                    if (state_reg.opc == csb_pkg::OP_ABS_JUMP || ex.condTrue) begin
                        state_next.pc = {memRdData, state_reg.tmpLo};
                    end else begin
                        state_next.pc = pcInc;
                    end
                    state_next = finishInstr(state_next, run);
                end
                csb_pkg::ST_RELDISP: begin
                    state_next.disp = memRdData;
                    state_next.pc = pcInc;
                    if (state_reg.opc == csb_pkg::OP_REL_JUMP || ex.condTrue) begin
                        state_next = enterCycle(state_next, csb_pkg::ST_RELADD, pcInc);
                    end else begin
                        state_next = finishInstr(state_next, run);
                    end
                end
                csb_pkg::ST_RELADD: begin
                    // counter already past both bytes, giving -126..+129 from opcode
                    state_next.pc = state_reg.pc + sext16(state_reg.disp);
                    state_next = finishInstr(state_next, run);
                end
                default: begin
                    state_next = enterCycle(state_next, csb_pkg::ST_IDLE, state_reg.pc);
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= '0;
            state_reg.pc <= csb_pkg::RESET_PC;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign memAddr = state_reg.memAddr;
    assign memRdEn = state_reg.memRdEn;
    assign memWrEn = state_reg.memWrEn;
    assign memWrData = state_reg.memWrData;
    assign opFetch = state_reg.opFetch;
    assign busy = state_reg.busy;
    assign instrDone = state_reg.instrDone;
    assign regView = state_reg.regView;

endmodule

// File: csb_pkg.sv
package csb_pkg;

    // ------------------------------------------------------------
    // opcode bytes and fields
    // ------------------------------------------------------------
    localparam logic [7:0] PFX_BIT = 8'hCB;
    localparam logic [7:0] PFX_IDX1 = 8'hDD;
    localparam logic [7:0] PFX_IDX2 = 8'hFD;
    localparam logic [7:0] OP_ABS_JUMP = 8'hC3;
    localparam logic [7:0] OP_REL_JUMP = 8'h18;
    localparam logic [7:0] OP_REL_NOCARRY = 8'h30;
    localparam logic [7:0] OP_REL_CARRY = 8'h38;
    localparam logic [1:0] GRP_CLEAR = 2'h2;
    localparam logic [1:0] GRP_ABS_COND = 2'h3;
    localparam logic [2:0] LOW_ABS_COND = 3'h2;
    localparam logic [2:0] FIELD_MEM = 3'h6;
    localparam logic [2:0] REG_ACC = 3'h7;

    // ------------------------------------------------------------
    // flag bit positions and condition codes
    // ------------------------------------------------------------
    localparam int FLAG_CARRY = 0;
    localparam int FLAG_PARITY = 2;
    localparam int FLAG_ZERO = 6;
    localparam int FLAG_SIGN = 7;
    localparam logic [2:0] CC_NZ = 3'h0;
    localparam logic [2:0] CC_Z = 3'h1;
    localparam logic [2:0] CC_NC = 3'h2;
    localparam logic [2:0] CC_C = 3'h3;
    localparam logic [2:0] CC_PO = 3'h4;
    localparam logic [2:0] CC_PE = 3'h5;
    localparam logic [2:0] CC_P = 3'h6;
    localparam logic [2:0] CC_M = 3'h7;

    // ------------------------------------------------------------
    // machine cycle lengths in clock states, stored as length - 1
    // ------------------------------------------------------------
    localparam logic [2:0] T_OPFETCH = 3'h3;
    localparam logic [2:0] T_MEMRD3 = 3'h2;
    localparam logic [2:0] T_MEMRD4 = 3'h3;
    localparam logic [2:0] T_MEMWR = 3'h2;
    localparam logic [2:0] T_IDXCALC = 3'h4;
    localparam logic [2:0] T_RELADD = 3'h4;

    // ------------------------------------------------------------
    // load and view selectors, reset values
    // ------------------------------------------------------------
    localparam logic [3:0] SEL_FLAGS = 4'h6;
    localparam logic [3:0] SEL_IDX1 = 4'h8;
    localparam logic [3:0] SEL_IDX2 = 4'h9;
    localparam logic [3:0] SEL_PC = 4'hA;
    localparam logic [15:0] RESET_PC = 16'h0000;

    typedef enum logic [3:0] {
        ST_IDLE, ST_FETCH, ST_BITOP, ST_DISP, ST_IDXOP, ST_MEMRD, ST_MEMWR,
        ST_IMMLO, ST_IMMHI, ST_RELDISP, ST_RELADD
    } csb_state_e;

endpackage

// File: csb_exec_if.sv
`timescale 1ns/1ns
interface csb_exec_if;
    logic [2:0] condCode;
    logic [7:0] flags;
    logic condTrue;
    logic [7:0] operand;
    logic [2:0] bitSel;
    logic [7:0] cleared;

    modport core (output condCode, output flags, input condTrue,
        output operand, output bitSel, input cleared);
    modport condSide (input condCode, input flags, output condTrue);
    modport clrSide (input operand, input bitSel, output cleared);
endinterface

// File: csb_cond_eval.sv
`timescale 1ns/1ns
module csb_cond_eval (
    // condition request and answer
    csb_exec_if.condSide ex
);
    always_comb begin
        case (ex.condCode)
            csb_pkg::CC_NZ: ex.condTrue = ~ex.flags[csb_pkg::FLAG_ZERO];
            csb_pkg::CC_Z: ex.condTrue = ex.flags[csb_pkg::FLAG_ZERO];
            csb_pkg::CC_NC: ex.condTrue = ~ex.flags[csb_pkg::FLAG_CARRY];
            csb_pkg::CC_C: ex.condTrue = ex.flags[csb_pkg::FLAG_CARRY];
            csb_pkg::CC_PO: ex.condTrue = ~ex.flags[csb_pkg::FLAG_PARITY];
            csb_pkg::CC_PE: ex.condTrue = ex.flags[csb_pkg::FLAG_PARITY];
            csb_pkg::CC_P: ex.condTrue = ~ex.flags[csb_pkg::FLAG_SIGN];
            csb_pkg::CC_M: ex.condTrue = ex.flags[csb_pkg::FLAG_SIGN];
            default: ex.condTrue = 1'b0;
        endcase
    end
endmodule

// File: csb_bit_clear.sv
`timescale 1ns/1ns
module csb_bit_clear (
    // operand in, cleared operand out
    csb_exec_if.clrSide ex
);
    // bit 0 is the least significant bit of the operand
    always_comb begin
        ex.cleared = ex.operand & ~(8'h01 << ex.bitSel);
    end
endmodule

// File: csb_branch_core_assertions.sv
`timescale 1ns/1ns
module csb_branch_core_assertions (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // control
    input wire logic run,
    input wire logic loadEn,
    input wire logic [3:0] loadSel,
    input wire logic [15:0] loadData,
    input wire logic [3:0] viewSel,
    // memory bus
    input wire logic [7:0] memRdData,
    input wire logic [15:0] memAddr,
    input wire logic memRdEn,
    input wire logic memWrEn,
    input wire logic [7:0] memWrData,
    input wire logic opFetch,
    // status
    input wire logic busy,
    input wire logic instrDone,
    input wire logic [15:0] regView
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // ----------------------------------------
    // bus cycle shapes
    // ----------------------------------------
    sequence s_read_same_addr;
        $past(memRdEn) && $stable(memAddr);
    endsequence
    sequence s_write3;
        memWrEn [*3] ##1 !memWrEn;
    endsequence
    property p_rmw_addr;
        $rose(memWrEn) |-> s_read_same_addr;
    endproperty
    a_rmw_addr: assert property (p_rmw_addr)
        else $error("write not after read of same byte");
    property p_wr_len;
        $rose(memWrEn) |-> s_write3;
    endproperty
    a_wr_len: assert property (p_wr_len) else $error("write cycle not three states");
    property p_wr_hold;
        memWrEn && $past(memWrEn) |-> $stable(memWrData) && $stable(memAddr);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write cycle changed mid way");
    property p_fetch_len;
        $rose(opFetch) |-> (opFetch && memRdEn) [*4];
    endproperty
    a_fetch_len: assert property (p_fetch_len)
        else $error("opcode fetch shorter than four");
    property p_start;
        $rose(busy) |-> opFetch && memRdEn && !memWrEn;
    endproperty
    a_start: assert property (p_start) else $error("instruction not begun by fetch");
    property p_done_next;
        instrDone |-> !busy || opFetch;
    endproperty
    a_done_next: assert property (p_done_next)
        else $error("end not followed by fetch or idle");
    property p_idle_bus;
        !busy |-> !memRdEn && !memWrEn && !opFetch;
    endproperty
    a_idle_bus: assert property (p_idle_bus) else $error("bus active while idle");
    // regView lags viewSel by one clock, hence the two-deep look back
    property p_flags_kept;
        busy && $past(busy) && viewSel == csb_pkg::SEL_FLAGS && $past(viewSel) == csb_pkg::SEL_FLAGS
            && $past(viewSel, 2) == csb_pkg::SEL_FLAGS |-> $stable(regView);
    endproperty
    a_flags_kept: assert property (p_flags_kept)
        else $error("flags changed during execution");
endmodule
bind csb_branch_core csb_branch_core_assertions i_csb_branch_core_assertions (
    .ref_clk(ref_clk), .nrst(nrst), .run(run), .loadEn(loadEn), .loadSel(loadSel),
    .loadData(loadData), .viewSel(viewSel), .memRdData(memRdData), .memAddr(memAddr),
    .memRdEn(memRdEn), .memWrEn(memWrEn), .memWrData(memWrData), .opFetch(opFetch),
    .busy(busy), .instrDone(instrDone), .regView(regView)
);

// File: csb_mem_model.sv
`timescale 1ns/1ns
module csb_mem_model (
    // clock
    input wire logic ref_clk,
    // memory bus
    input wire logic [15:0] memAddr,
    input wire logic memRdEn,
    input wire logic memWrEn,
    input wire logic [7:0] memWrData,
    output logic [7:0] memRdData
);
    logic [7:0] mem [0:65535];
    logic [7:0] lastRd = 8'h00;
    // released bus shows the inverse of the last byte, so stale data never passes
    assign memRdData = memRdEn ? mem[memAddr] : ~lastRd;
    always @(posedge ref_clk) begin
        if (memRdEn) begin
            lastRd <= mem[memAddr];
        end
        if (memWrEn) begin
            mem[memAddr] <= memWrData;
        end
    end
endmodule

// File: csb_branch_core_bench.sv
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %0t mismatch got %h exp %h", $time, g, e); end end
module csb_branch_core_bench;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic run = 1'b0;
    logic loadEn = 1'b0;
    logic [3:0] loadSel = 4'h0;
    logic [15:0] loadData = 16'h0000;
    logic [3:0] viewSel = 4'h6;
    logic [7:0] memRdData, memWrData;
    logic [15:0] memAddr, regView;
    logic memRdEn, memWrEn, opFetch, busy, instrDone;
    int fails = 0;
    int compares = 0;
    logic [7:0] rg [0:7];
    logic [15:0] ix [0:1];
    logic [7:0] fl, d, op;
    logic [15:0] pc, a, v;
    logic [2:0] b;
    logic tk;
    int fb [0:3] = '{csb_pkg::FLAG_ZERO, csb_pkg::FLAG_CARRY, csb_pkg::FLAG_PARITY,
        csb_pkg::FLAG_SIGN};
    always #25 ref_clk = ~ref_clk;
    csb_branch_core i_csb_branch_core (.ref_clk(ref_clk), .nrst(nrst), .run(run),
        .loadEn(loadEn), .loadSel(loadSel), .loadData(loadData), .viewSel(viewSel),
        .memRdData(memRdData), .memAddr(memAddr), .memRdEn(memRdEn), .memWrEn(memWrEn),
        .memWrData(memWrData), .opFetch(opFetch), .busy(busy), .instrDone(instrDone),
        .regView(regView));
    csb_mem_model i_csb_mem_model (.ref_clk(ref_clk), .memAddr(memAddr), .memRdEn(memRdEn),
        .memWrEn(memWrEn), .memWrData(memWrData), .memRdData(memRdData));
    // ----------------------------------------
    // drivers
    // ----------------------------------------
    task automatic end_sim();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic put(input logic [15:0] at, input logic [7:0] x);
        i_csb_mem_model.mem[at] = x;
    endtask
    task automatic ld(input logic [3:0] s, input logic [15:0] x);
        @(negedge ref_clk);
        loadEn = 1'b1;
        loadSel = s;
        loadData = x;
        @(negedge ref_clk);
        loadEn = 1'b0;
    endtask
    task automatic look(input logic [3:0] s);
        @(negedge ref_clk);
        viewSel = s;
        repeat (2) @(negedge ref_clk);
        v = regView;
    endtask
    // code stays below 8000h except one relative jump placed at FFF0h that reads no data, data pointers above 8000h, so they never overlap
    task automatic setup(input logic [7:0] f, input logic [15:0] p);
        for (int i = 0; i < 8; i++) begin
            rg[i] = 8'($urandom());
        end
        rg[4][7] = 1'b1;
        rg[6] = f;
        fl = f;
        ix[0] = 16'hC000 | 16'($urandom_range(0, 8191));
        ix[1] = 16'hC000 | 16'($urandom_range(0, 8191));
        pc = p;
        for (int i = 0; i < 11; i++) begin
            ld(4'(i), i > 7 ? (i == 10 ? pc : ix[i - 8]) : {8'h00, rg[i]});
        end
    endtask
    task automatic exec(input int n, input logic [15:0] pcExp);
        int cnt;
        look(csb_pkg::SEL_FLAGS);
        @(negedge ref_clk);
        run = 1'b1;
        @(negedge ref_clk);
        run = 1'b0;
        cnt = 0;
        `CHK(busy, 1'b1)
        while (instrDone !== 1'b1) begin
            @(posedge ref_clk);
            #1;
            cnt++;
            if (cnt > 40) begin
                $display("[ERR] %0t timeout waiting for instruction end", $time);
                fails++;
                end_sim();
            end
        end
        `CHK(cnt, n)
        look(csb_pkg::SEL_PC);
        `CHK(v, pcExp)
        look(csb_pkg::SEL_FLAGS);
        `CHK(v, ({8'h00, fl}))
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        void'($urandom(72045));
        repeat (2) @(negedge ref_clk);
        nrst = 1'b1;
        for (int r = 0; r < 8; r++) begin
            if (r != 6) begin
                setup(8'($urandom()), 16'($urandom()) & 16'h7FF0);
                b = 3'($urandom());
                put(pc, csb_pkg::PFX_BIT);
                put(pc + 16'h0001, {2'h2, b, 3'(r)});
                exec(8, pc + 16'h0002);
                look(4'(r));
                `CHK(v, ({8'h00, rg[r] & ~(8'h01 << b)}))
            end
        end
        for (int i = 0; i < 8; i++) begin
            setup(8'($urandom()), 16'($urandom()) & 16'h7FF0);
            a = {rg[4], rg[5]};
            d = 8'($urandom());
            put(a, d);
            put(pc, csb_pkg::PFX_BIT);
            put(pc + 16'h0001, {2'h2, 3'(i), csb_pkg::FIELD_MEM});
            exec(15, pc + 16'h0002);
            `CHK(i_csb_mem_model.mem[a], d & ~(8'h01 << i))
        end
        for (int i = 0; i < 6; i++) begin
            setup(8'($urandom()), 16'($urandom()) & 16'h7FF0);
            d = (i % 3 == 0) ? 8'h80 : (i % 3 == 1) ? 8'h7F : 8'($urandom());
            a = ix[i / 3] + {{8{d[7]}}, d};
            b = 3'($urandom());
            op = 8'($urandom());
            put(a, op);
            put(pc, i < 3 ? csb_pkg::PFX_IDX1 : csb_pkg::PFX_IDX2);
            put(pc + 16'h0001, csb_pkg::PFX_BIT);
            put(pc + 16'h0002, d);
            put(pc + 16'h0003, {2'h2, b, csb_pkg::FIELD_MEM});
            exec(23, pc + 16'h0004);
            `CHK(i_csb_mem_model.mem[a], op & ~(8'h01 << b))
        end
        for (int i = 0; i < 17; i++) begin
            a = 16'($urandom());
            op = (i == 16) ? csb_pkg::OP_ABS_JUMP
                : {csb_pkg::GRP_ABS_COND, 3'(i / 2), csb_pkg::LOW_ABS_COND};
            d = 8'($urandom());
            d[fb[(i / 4) % 4]] = (i % 2 == 0) ? op[3] : ~op[3];
            setup(d, 16'($urandom()) & 16'h7FF0);
            put(pc, op);
            put(pc + 16'h0001, a[7:0]);
            put(pc + 16'h0002, a[15:8]);
            exec(10, (i == 16 || i % 2 == 0) ? a : pc + 16'h0003);
        end
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom());
            d[csb_pkg::FLAG_CARRY] = i[0];
            setup(d, i == 3 ? 16'hFFF0 : 16'($urandom()) & 16'h7FF0);
            tk = (i < 4) ? 1'b1 : (i < 6) ? ~i[0] : i[0];
            d = (i == 0) ? 8'h80 : (i == 3 || i == 1) ? 8'h7F : 8'($urandom());
            op = (i < 4) ? csb_pkg::OP_REL_JUMP : (i < 6) ? csb_pkg::OP_REL_NOCARRY
                : csb_pkg::OP_REL_CARRY;
            put(pc, op);
            put(pc + 16'h0001, d);
            a = tk ? pc + 16'h0002 + {{8{d[7]}}, d} : pc + 16'h0002;
            exec(tk ? 12 : 7, a);
        end
        end_sim();
    end
endmodule
